// file: ifm_bank.sv
// Interrupt flag, mask and key-line selection register bank
//
// Summary of operation
// - Address c0 bit 0 is the read-only programmable timer flag, zero after reset.
// - Address c1 bit 0 is the read-only serial transfer flag, zero after reset.
// - Address c2 bit 0 is the read-only single key flag, zero after reset.
// - Address c3 bit 0 is the read-only key group flag, zero after reset.
// - Address c4 bit 0 is the read-only conversion flag, zero after reset.
// - Address c5 holds stopwatch 1 Hz flag in bit 1 and 10 Hz flag in bit 0, zero after reset.
// - Address c6 holds clock tick flags 1, 2, 8, 32 Hz in bits 3 to 0, zero after reset.
// - Address c8 holds conversion, serial and timer enables in bits 2 to 0, one enables, reset zero.
// - Address c9 holds single key and key group enables in bits 1 and 0, reset zero.
// - Address ca holds per-line key group selects in bits 3 to 0, reset zero.
// - Address cb holds stopwatch 1 Hz and 10 Hz enables in bits 1 and 0, upper bits read zero.
// - Address cc holds clock tick enables for 1, 2, 8, 32 Hz in bits 3 to 0, reset zero.
// - Reading a flag register clears its flags, but an event in that cycle survives.
// - With several enabled events pending the highest vector, 10e down to 102, is given.
`timescale 1ns/1ps
module ifm_bank
    import ifm_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [3:0]  wdata_i,
    output logic      [3:0]  rdata_o,
    input  wire logic        prog_timer_event_i,
    input  wire logic        serial_event_i,
    input  wire logic        single_key_event_i,
    input  wire logic [3:0]  key_group_lines_event_i,
    input  wire logic        conversion_event_i,
    input  wire logic [1:0]  stopwatch_event_i,
    input  wire logic [3:0]  clock_tick_event_i,
    output logic             irq_o,
    output logic      [7:0]  irq_vector_o,
    output logic      [3:0]  key_line_select_o
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    logic [6:0] rd_clr;
    assign rd_clr[SRC_PROG_TIMER] = rd_i && hit(addr_i, ADDR_PROG_TIMER_FLAG);
    assign rd_clr[SRC_SERIAL]     = rd_i && hit(addr_i, ADDR_SERIAL_FLAG);
    assign rd_clr[SRC_SINGLE_KEY] = rd_i && hit(addr_i, ADDR_SINGLE_KEY_FLAG);
    assign rd_clr[SRC_KEY_GROUP]  = rd_i && hit(addr_i, ADDR_KEY_GROUP_FLAG);
    assign rd_clr[SRC_CONVERSION] = rd_i && hit(addr_i, ADDR_CONVERSION_FLAG);
    assign rd_clr[SRC_STOPWATCH]  = rd_i && hit(addr_i, ADDR_STOPWATCH_FLAG);
    assign rd_clr[SRC_CLOCK_TICK] = rd_i && hit(addr_i, ADDR_CLOCK_TICK_FLAG);

    // ----------------------------------------------------------------
    // Enable and selection registers
    // ----------------------------------------------------------------
    logic [2:0] periph_ena_ff;
    logic [1:0] key_ena_ff;
    logic [3:0] key_sel_ff;
    logic [1:0] sw_ena_ff;
    logic [3:0] tick_ena_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            periph_ena_ff <= RESET_VALUE[2:0];
            key_ena_ff    <= RESET_VALUE[1:0];
            key_sel_ff    <= RESET_VALUE;
            sw_ena_ff     <= RESET_VALUE[1:0];
            tick_ena_ff   <= RESET_VALUE;
        end else if (wr_i) begin
            if (hit(addr_i, ADDR_PERIPH_ENABLE))   periph_ena_ff <= wdata_i[2:0];
            if (hit(addr_i, ADDR_KEY_ENABLE))      key_ena_ff    <= wdata_i[1:0];
            if (hit(addr_i, ADDR_KEY_LINE_SELECT)) key_sel_ff    <= wdata_i;
            if (hit(addr_i, ADDR_STOPWATCH_ENA))   sw_ena_ff     <= wdata_i[1:0];
            if (hit(addr_i, ADDR_CLOCK_TICK_ENA))  tick_ena_ff   <= wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    // Deselected key lines never reach the group flag
    logic       key_group_hit;
    assign key_group_hit = |(key_group_lines_event_i & key_sel_ff);

    logic [3:0] f_pt, f_sio, f_sk, f_kg, f_ad, f_sw, f_tk;

    ifm_flag_nibble u_pt (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_PROG_TIMER]),
        .set_i({3'h0, prog_timer_event_i}), .flag_o(f_pt));
    ifm_flag_nibble u_sio (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_SERIAL]),
        .set_i({3'h0, serial_event_i}), .flag_o(f_sio));
    ifm_flag_nibble u_sk (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_SINGLE_KEY]),
        .set_i({3'h0, single_key_event_i}), .flag_o(f_sk));
    ifm_flag_nibble u_kg (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_KEY_GROUP]),
        .set_i({3'h0, key_group_hit}), .flag_o(f_kg));
    ifm_flag_nibble u_ad (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_CONVERSION]),
        .set_i({3'h0, conversion_event_i}), .flag_o(f_ad));
    ifm_flag_nibble u_sw (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_STOPWATCH]),
        .set_i({2'h0, stopwatch_event_i}), .flag_o(f_sw));
    ifm_flag_nibble u_tk (.mclk_i(mclk_i), .reset_i(reset_i), .rd_clr_i(rd_clr[SRC_CLOCK_TICK]),
        .set_i(clock_tick_event_i), .flag_o(f_tk));

    // ----------------------------------------------------------------
    // Read data, registered; flags show their value before the clear
    // ----------------------------------------------------------------
    logic [3:0] nxt_rdata;
    logic [3:0] rdata_ff;

    always_comb begin
        nxt_rdata = ZERO_NIBBLE;
        unique case (addr_i)
            ADDR_PROG_TIMER_FLAG: nxt_rdata = {3'h0, f_pt[0]};
            ADDR_SERIAL_FLAG:     nxt_rdata = {3'h0, f_sio[0]};
            ADDR_SINGLE_KEY_FLAG: nxt_rdata = {3'h0, f_sk[0]};
            ADDR_KEY_GROUP_FLAG:  nxt_rdata = {3'h0, f_kg[0]};
            ADDR_CONVERSION_FLAG: nxt_rdata = {3'h0, f_ad[0]};
            ADDR_STOPWATCH_FLAG:  nxt_rdata = {2'h0, f_sw[1:0]};
            ADDR_CLOCK_TICK_FLAG: nxt_rdata = f_tk;
            ADDR_PERIPH_ENABLE:   nxt_rdata = {1'h0, periph_ena_ff};
            ADDR_KEY_ENABLE:      nxt_rdata = {2'h0, key_ena_ff};
            ADDR_KEY_LINE_SELECT: nxt_rdata = key_sel_ff;
            ADDR_STOPWATCH_ENA:   nxt_rdata = {2'h0, sw_ena_ff};
            ADDR_CLOCK_TICK_ENA:  nxt_rdata = tick_ena_ff;
            default:              nxt_rdata = ZERO_NIBBLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_ff <= ZERO_NIBBLE;
        end else if (rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // Request and vector
    // ----------------------------------------------------------------
    logic [6:0] pend;
    assign pend[SRC_PROG_TIMER] = f_pt[0] & periph_ena_ff[0];
    assign pend[SRC_SERIAL]     = f_sio[0] & periph_ena_ff[1];
    assign pend[SRC_CONVERSION] = f_ad[0] & periph_ena_ff[2];
    assign pend[SRC_KEY_GROUP]  = f_kg[0] & key_ena_ff[0];
    assign pend[SRC_SINGLE_KEY] = f_sk[0] & key_ena_ff[1];
    assign pend[SRC_STOPWATCH]  = |(f_sw[1:0] & sw_ena_ff);
    assign pend[SRC_CLOCK_TICK] = |(f_tk & tick_ena_ff);

    logic [7:0] nxt_vector;
    ifm_priority_enc u_enc (.pend_i(pend), .vec_o(nxt_vector));

    logic       irq_ff;
    logic [7:0] vector_ff;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_ff    <= 1'b0;
            vector_ff <= VEC_NONE;
        end else begin
            irq_ff    <= |pend;
            vector_ff <= nxt_vector;
        end
    end
    assign irq_o             = irq_ff;
    assign irq_vector_o      = vector_ff;
    assign key_line_select_o = key_sel_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_IRQ_FOLLOWS_PEND: assert property (@(posedge mclk_i) disable iff (reset_i)
        ##1 (irq_o == $past(|pend)))
        else $error("request does not follow pending sources");
    AST_TIMER_WINS: assert property (@(posedge mclk_i) disable iff (reset_i)
        pend[SRC_PROG_TIMER] |=> (irq_vector_o == VEC_PROG_TIMER))
        else $error("timer vector not chosen");
    AST_TICK_LOWEST: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pend == 7'h01) |=> (irq_vector_o == VEC_CLOCK_TICK))
        else $error("clock tick vector wrong");
    AST_MASKED_NO_IRQ: assert property (@(posedge mclk_i) disable iff (reset_i)
        (periph_ena_ff == 3'h0 && key_ena_ff == 2'h0 && sw_ena_ff == 2'h0 && tick_ena_ff == 4'h0)
        |=> !irq_o)
        else $error("request while all masked");
    AST_ENABLE_WRITE: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && addr_i == ADDR_CLOCK_TICK_ENA) |=> (tick_ena_ff == $past(wdata_i)))
        else $error("enable write lost");
    AST_SW_UPPER_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rd_i && addr_i == ADDR_STOPWATCH_ENA) |=> (rdata_o[3:2] == 2'h0))
        else $error("upper stopwatch enable bits not zero");
    AST_FLAG_READBACK: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rd_i && addr_i == ADDR_PROG_TIMER_FLAG) |=> (rdata_o == {3'h0, $past(f_pt[0])}))
        else $error("timer flag read wrong");
    AST_READ_THEN_CLEAR: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rd_i && addr_i == ADDR_CLOCK_TICK_FLAG && clock_tick_event_i == 4'h0) |=> (f_tk == 4'h0))
        else $error("tick flags not cleared by read");
    AST_KEY_SELECT: assert property (@(posedge mclk_i) disable iff (reset_i)
        (key_sel_ff == 4'h0 && !rd_clr[SRC_KEY_GROUP] && f_kg == 4'h0) |=> (f_kg == 4'h0))
        else $error("deselected key line raised flag");

    COV_IRQ: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(irq_o));
    COV_TWO_PEND: cover property (@(posedge mclk_i) disable iff (reset_i) pend[SRC_SERIAL] && pend[SRC_STOPWATCH]);
    COV_SET_ON_CLEAR: cover property (@(posedge mclk_i) disable iff (reset_i)
        rd_clr[SRC_SERIAL] && serial_event_i);
endmodule : ifm_bank

// file: ifm_pkg.sv
// Package: addresses, field positions and codes of the interrupt flag and mask bank
package ifm_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 4;
    localparam logic [7:0] ADDR_PROG_TIMER_FLAG = 8'hc0;
    localparam logic [7:0] ADDR_SERIAL_FLAG     = 8'hc1;
    localparam logic [7:0] ADDR_SINGLE_KEY_FLAG = 8'hc2;
    localparam logic [7:0] ADDR_KEY_GROUP_FLAG  = 8'hc3;
    localparam logic [7:0] ADDR_CONVERSION_FLAG = 8'hc4;
    localparam logic [7:0] ADDR_STOPWATCH_FLAG  = 8'hc5;
    localparam logic [7:0] ADDR_CLOCK_TICK_FLAG = 8'hc6;
    localparam logic [7:0] ADDR_PERIPH_ENABLE   = 8'hc8;
    localparam logic [7:0] ADDR_KEY_ENABLE      = 8'hc9;
    localparam logic [7:0] ADDR_KEY_LINE_SELECT = 8'hca;
    localparam logic [7:0] ADDR_STOPWATCH_ENA   = 8'hcb;
    localparam logic [7:0] ADDR_CLOCK_TICK_ENA  = 8'hcc;
    localparam logic [3:0] RESET_VALUE          = 4'h0;
    localparam logic [3:0] ZERO_NIBBLE          = 4'h0;
    // Source index, lowest to highest priority
    localparam int unsigned SRC_CLOCK_TICK = 0;
    localparam int unsigned SRC_STOPWATCH  = 1;
    localparam int unsigned SRC_CONVERSION = 2;
    localparam int unsigned SRC_KEY_GROUP  = 3;
    localparam int unsigned SRC_SINGLE_KEY = 4;
    localparam int unsigned SRC_SERIAL     = 5;
    localparam int unsigned SRC_PROG_TIMER = 6;
    localparam int unsigned NUM_SRC        = 7;
    // Vector low byte; page 1 is implied
    localparam logic [7:0] VEC_NONE        = 8'h00;
    localparam logic [7:0] VEC_CLOCK_TICK  = 8'h02;
    localparam logic [7:0] VEC_STOPWATCH   = 8'h04;
    localparam logic [7:0] VEC_CONVERSION  = 8'h06;
    localparam logic [7:0] VEC_KEY_GROUP   = 8'h08;
    localparam logic [7:0] VEC_SINGLE_KEY  = 8'h0a;
    localparam logic [7:0] VEC_SERIAL      = 8'h0c;
    localparam logic [7:0] VEC_PROG_TIMER  = 8'h0e;
endpackage : ifm_pkg

// file: ifm_flag_nibble.sv
// Four sticky event flags, cleared on read, set wins over clear
`timescale 1ns/1ps
module ifm_flag_nibble
    import ifm_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  set_i,
    input  wire logic        rd_clr_i,
    output logic      [3:0]  flag_o
);
    logic [3:0] flag_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            flag_ff <= RESET_VALUE;
        end else if (rd_clr_i) begin
            flag_ff <= set_i;
        end else begin
            flag_ff <= flag_ff | set_i;
        end
    end

    assign flag_o = flag_ff;

    AST_SET_STICKS: assert property (@(posedge mclk_i) disable iff (reset_i)
        |set_i |=> ((flag_ff & $past(set_i)) == $past(set_i)))
        else $error("event lost");
    AST_READ_CLEARS: assert property (@(posedge mclk_i) disable iff (reset_i)
        rd_clr_i |=> (flag_ff == $past(set_i)))
        else $error("read did not clear flags");
endmodule : ifm_flag_nibble

// file: ifm_priority_enc.sv
// Highest pending enabled source to vector
`timescale 1ns/1ps
module ifm_priority_enc
    import ifm_pkg::*;
(
    input  wire logic [6:0] pend_i,
    output logic      [7:0] vec_o
);
    always_comb begin
        vec_o = VEC_NONE;
        if (pend_i[SRC_PROG_TIMER]) begin
            vec_o = VEC_PROG_TIMER;
        end else if (pend_i[SRC_SERIAL]) begin
            vec_o = VEC_SERIAL;
        end else if (pend_i[SRC_SINGLE_KEY]) begin
            vec_o = VEC_SINGLE_KEY;
        end else if (pend_i[SRC_KEY_GROUP]) begin
            vec_o = VEC_KEY_GROUP;
        end else if (pend_i[SRC_CONVERSION]) begin
            vec_o = VEC_CONVERSION;
        end else if (pend_i[SRC_STOPWATCH]) begin
            vec_o = VEC_STOPWATCH;
        end else if (pend_i[SRC_CLOCK_TICK]) begin
            vec_o = VEC_CLOCK_TICK;
        end
    end
endmodule : ifm_priority_enc

// file: ifm_cpu_model.sv
// CPU-side model that issues I/O memory reads and writes to the bank
`timescale 1ns/1ps
module ifm_cpu_model (
    input  wire logic       mclk_i,
    output logic      [7:0] addr_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic      [3:0] wdata_o,
    input  wire logic [3:0] rdata_i
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    initial begin
        addr_o  = 8'h00;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 4'h0;
    end

    // Released lines show the inverse so a stale value is never mistaken for a hold
    task automatic write_io(input logic [7:0] a, input logic [3:0] d);
        @(posedge mclk_i);
        #1;
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(posedge mclk_i);
        #1;
        wr_o    = 1'b0;
        wdata_o = ~d;
        addr_o  = ~a;
    endtask : write_io

    // Read data is registered, so it is taken one edge after the strobe edge
    task automatic read_io(input logic [7:0] a, output logic [3:0] d);
        @(posedge mclk_i);
        #1;
        addr_o = a;
        rd_o   = 1'b1;
        @(posedge mclk_i);
        #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        d      = rdata_i;
    endtask : read_io
endmodule : ifm_cpu_model

// file: ifm_bank_test.sv
// Self-checking testbench of the interrupt flag and mask bank
`timescale 1ns/1ps
module ifm_bank_test;
    import ifm_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [13:0] ev = 14'h0000;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [3:0]  wdata;
    logic [3:0]  rdata;
    logic        irq;
    logic [7:0]  vec;
    logic [3:0]  sel;
    logic [3:0]  got;
    int          err_total = 0;
    int          cmp_count = 0;
    localparam logic [7:0] EN_ADDR [5] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc};
    localparam logic [3:0] EN_EXP  [5] = '{4'h7, 4'h3, 4'hf, 4'h3, 4'hf};
    localparam logic [3:0] FL_EXP  [7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'hf};
    localparam logic [7:0] VEC_EXP [7] = '{VEC_SERIAL, VEC_SINGLE_KEY, VEC_KEY_GROUP, VEC_CONVERSION,
                                          VEC_STOPWATCH, VEC_CLOCK_TICK, VEC_NONE};

    always #2.5 mclk_i = ~mclk_i;

    ifm_cpu_model u_ifm_cpu_model (.mclk_i(mclk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr),
                                   .wdata_o(wdata), .rdata_i(rdata));
    ifm_bank u_ifm_bank (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .rd_i(rd), .wr_i(wr),
        .wdata_i(wdata), .rdata_o(rdata), .prog_timer_event_i(ev[13]), .serial_event_i(ev[12]),
        .single_key_event_i(ev[11]), .key_group_lines_event_i(ev[10:7]), .conversion_event_i(ev[6]),
        .stopwatch_event_i(ev[5:4]), .clock_tick_event_i(ev[3:0]), .irq_o(irq), .irq_vector_o(vec),
        .key_line_select_o(sel));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Event pulse of one cycle, then one more edge so the request has settled
    task automatic pulse(input logic [13:0] v);
        @(posedge mclk_i);
        #1;
        ev = v;
        @(posedge mclk_i);
        #1;
        ev = 14'h0000;
        @(posedge mclk_i);
        #1;
    endtask : pulse

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // Whole run is about a hundred cycles; this span leaves wide margin
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        for (int i = 0; i < 14; i++) begin
            u_ifm_cpu_model.read_io(8'hc0 + 8'(i), got);
            chk("reset value", 8'h00, {4'h0, got});
        end
        chk("irq at reset", 8'h00, {7'h00, irq});
        $display("test reset_values done");

        for (int i = 0; i < 5; i++) begin
            u_ifm_cpu_model.write_io(EN_ADDR[i], 4'hf);
            u_ifm_cpu_model.read_io(EN_ADDR[i], got);
            chk("enable register", {4'h0, EN_EXP[i]}, {4'h0, got});
        end
        chk("key select out", 8'h0f, {4'h0, sel});
        u_ifm_cpu_model.write_io(ADDR_PROG_TIMER_FLAG, 4'hf);
        u_ifm_cpu_model.read_io(ADDR_PROG_TIMER_FLAG, got);
        chk("flag write ignored", 8'h00, {4'h0, got});
        $display("test enable_registers done");

        pulse(14'h3fff);
        chk("irq all pending", 8'h01, {7'h00, irq});
        chk("vector all pending", VEC_PROG_TIMER, vec);
        for (int i = 0; i < 7; i++) begin
            u_ifm_cpu_model.read_io(8'hc0 + 8'(i), got);
            chk("flag read", {4'h0, FL_EXP[i]}, {4'h0, got});
            @(posedge mclk_i);
            #1;
            chk("vector after clear", VEC_EXP[i], vec);
        end
        chk("irq all cleared", 8'h00, {7'h00, irq});
        u_ifm_cpu_model.read_io(ADDR_CLOCK_TICK_FLAG, got);
        chk("flag after clear", 8'h00, {4'h0, got});
        $display("test priority_and_clear done");

        u_ifm_cpu_model.write_io(ADDR_CLOCK_TICK_ENA, 4'h0);
        u_ifm_cpu_model.write_io(ADDR_KEY_LINE_SELECT, 4'h1);
        pulse(14'h0101);
        chk("irq masked", 8'h00, {7'h00, irq});
        u_ifm_cpu_model.read_io(ADDR_CLOCK_TICK_FLAG, got);
        chk("masked flag still set", 8'h01, {4'h0, got});
        u_ifm_cpu_model.read_io(ADDR_KEY_GROUP_FLAG, got);
        chk("unselected line", 8'h00, {4'h0, got});
        pulse(14'h0080);
        chk("vector key group", VEC_KEY_GROUP, vec);
        u_ifm_cpu_model.read_io(ADDR_KEY_GROUP_FLAG, got);
        chk("selected line", 8'h01, {4'h0, got});
        $display("test mask_and_select done");

        fork
            u_ifm_cpu_model.read_io(ADDR_SERIAL_FLAG, got);
            begin
                @(posedge mclk_i);
                #1;
                ev = 14'h1000;
                @(posedge mclk_i);
                #1;
                ev = 14'h0000;
            end
        join
        chk("flag before set on clear", 8'h00, {4'h0, got});
        u_ifm_cpu_model.read_io(ADDR_SERIAL_FLAG, got);
        chk("event survives clear", 8'h01, {4'h0, got});
        u_ifm_cpu_model.read_io(ADDR_SERIAL_FLAG, got);
        chk("flag cleared after read", 8'h00, {4'h0, got});
        $display("test set_wins_clear done");
        end_of_test();
    end
endmodule : ifm_bank_test
